/* dv/cpmc_link_partner.sv */
// Link partner model: cable energy, pages, next pages and pair faults
`default_nettype none
module cpmc_link_partner (
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic [3:0]  plug_in,
    input  wire logic        aneg_in,
    input  wire logic [7:0]  wait_in,
    input  wire logic [1:0]  rate_in,
    input  wire logic [5:0]  abil_in,
    input  wire logic [7:0]  seed_in,
    input  wire logic [3:0]  np_send_in,
    input  wire logic [10:0] np_word_in,
    input  wire logic [3:0]  pol_in,
    input  wire logic        swap_in,
    output wire logic [3:0]  energy_out,
    output wire logic [7:0]  rate_out,
    output var  logic [3:0]  page_out,
    output var  logic [23:0] abil_out,
    output var  logic [31:0] seed_out,
    output var  logic [3:0]  np_valid_out,
    output var  logic [43:0] np_out,
    output wire logic [3:0]  swap_out,
    output wire logic [15:0] pol_out
);
    timeunit 1ns / 1ns;
    logic [7:0] age [4];
    assign energy_out = plug_in;
    assign rate_out = {4{rate_in}};
    assign swap_out = {4{swap_in}};
    assign pol_out = {4{pol_in}};
    // Fields flip outside valid cycles so stale data never looks valid
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            age <= '{default: 8'h00};
            page_out <= 4'h0;
            np_valid_out <= 4'h0;
            abil_out <= 24'h000000;
            seed_out <= 32'h00000000;
            np_out <= 44'h00000000000;
        end else begin
            for (int p = 0; p < 4; p++) begin
                age[p] <= plug_in[p] ? age[p] + 8'(age[p] != 8'hFF) : 8'h00;
                page_out[p] <= aneg_in && plug_in[p] && age[p] == wait_in;
                abil_out[p*6 +: 6] <= age[p] == wait_in ? abil_in
                                                        : ~abil_out[p*6 +: 6];
                seed_out[p*8 +: 8] <= age[p] == wait_in ? seed_in
                                                        : ~seed_out[p*8 +: 8];
                np_valid_out[p] <= np_send_in[p];
                np_out[p*11 +: 11] <= np_send_in[p] ? np_word_in
                                                    : ~np_out[p*11 +: 11];
            end
        end
    end
endmodule
`default_nettype wire

/* dv/cpmc_port_mode_control_asserts.sv */
// Assertion checker for the per-port copper mode control block
`default_nettype none
module cpmc_mode_checker (
    input wire logic        core_clk_in,
    input wire logic        reset_in,
    input wire logic [2:0]  address_strap_pins_in,
    input wire logic        addr_reverse_in,
    input wire logic [3:0]  aneg_en_in,
    input wire logic [3:0]  speed_lsb_in,
    input wire logic [3:0]  speed_msb_in,
    input wire logic [3:0]  duplex_in,
    input wire logic [3:0]  line_energy_in,
    input wire logic [3:0]  forced_gig_test_in,
    input wire logic [3:0]  auto_xover_dis_in,
    input wire logic [3:0]  forced_xover_dis_in,
    input wire logic [7:0]  manual_xover_in,
    input wire logic [3:0]  mac_aneg_en_in,
    input wire logic [19:0] port_addr_out,
    input wire logic [3:0]  link_up_out,
    input wire logic [7:0]  speed_out,
    input wire logic [3:0]  gig_test_out,
    input wire logic [3:0]  crossed_wiring_mode_out,
    input wire logic [3:0]  xover_auto_out,
    input wire logic [3:0]  mac_aneg_run_out,
    input wire logic [63:0] mac_word_out
);
    timeunit 1ns / 1ns;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    addr_strap_a: assert property (!$past(reset_in) |->
        port_addr_out[19:17] == $past(address_strap_pins_in))
        else $error("strap bits missing from address");
    addr_low_a: assert property (!$past(reset_in) |->
        port_addr_out[16:15] == ($past(addr_reverse_in) ? 2'h0 : 2'h3))
        else $error("port index bits wrong");
    mac_run_a: assert property (mac_aneg_run_out == mac_aneg_en_in)
        else $error("MAC negotiation run differs from enable");
    mac_quiet_a: assert property (!mac_aneg_en_in[0] |=>
        mac_word_out[15:0] == 16'h0000) else $error("MAC word not quiet");
    aneg_stop_a: assert property ($fell(aneg_en_in[0]) |=>
        !link_up_out[0]) else $error("link held after negotiation off");
    gig_test_a: assert property ((forced_gig_test_in[0] &&
        speed_msb_in[0] && !speed_lsb_in[0] && !aneg_en_in[0] &&
        $stable({duplex_in[0], line_energy_in[0]}))[*4] |=>
        gig_test_out[0] && speed_out[1:0] == 2'h2)
        else $error("forced gigabit test not entered");
    manual_x_a: assert property (manual_xover_in[1] |->
        !xover_auto_out[0] ##1
        crossed_wiring_mode_out[0] == $past(manual_xover_in[0]))
        else $error("manual wiring not forced");
    auto_off_a: assert property (auto_xover_dis_in[0] &&
        !manual_xover_in[1] |-> !xover_auto_out[0] ##1
        !crossed_wiring_mode_out[0]) else $error("disabled crossover active");
    forced_x_a: assert property (!auto_xover_dis_in[0] &&
        !manual_xover_in[1] && !forced_gig_test_in[0] |-> xover_auto_out[0]
        == (aneg_en_in[0] || !forced_xover_dis_in[0]))
        else $error("crossover enable wrong in forced mode");
    cover property (link_up_out[0] && speed_out[1:0] == 2'h1);
    cover property (gig_test_out[0]);
    cover property (xover_auto_out[0] && $changed(crossed_wiring_mode_out[0]));
endmodule
bind cpmc_port_mode_control cpmc_mode_checker i_cpmc_mode_checker (.*);
`default_nettype wire

/* dv/cpmc_port_mode_control_bench.sv */
// Self-checking bench for the per-port copper mode control block
`default_nettype none
module cpmc_port_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] sp;
        logic       d;
        logic       t;
        logic [1:0] es;
        logic       eg;
    } cpmc_row_t;
    cpmc_row_t   rows [5] = '{7'h00, 7'h32, 7'h5D, 7'h44, 7'h70};
    logic        core_clk_in, reset_in, addr_reverse_in, p_aneg, swap, last;
    logic [2:0]  address_strap_pins_in;
    logic [3:0]  aneg_en_in, speed_lsb_in, speed_msb_in, duplex_in;
    logic [3:0]  forced_gig_test_in, auto_xover_dis_in, polarity_fix_dis_in;
    logic [3:0]  forced_xover_dis_in, mac_aneg_en_in, mac_sgmii_sel_in;
    logic [3:0]  mac_np_valid_in, plug, psend, pol;
    logic [7:0]  manual_xover_in, wt, pseed;
    logic [1:0]  rate;
    logic [5:0]  pabil;
    logic [10:0] npw;
    logic [23:0] local_abil_in;
    logic [31:0] local_seed_in;
    logic [43:0] mac_np_in;
    int          n_errors, checked, n;
    wire  [3:0]  line_energy_in, partner_page_valid_in, partner_np_valid_in;
    wire  [3:0]  cd_swap_in, link_up_out, duplex_out, master_out;
    wire  [3:0]  aneg_done_out, par_det_out, gig_test_out, ms_fault_out;
    wire  [3:0]  crossed_wiring_mode_out, xover_auto_out, np_tx_valid_out;
    wire  [3:0]  np_rx_valid_out, mac_aneg_run_out, cd_swap_out;
    wire  [7:0]  line_rate_in, speed_out;
    wire  [15:0] pair_pol_err_in, polarity_inv_out;
    wire  [19:0] port_addr_out;
    wire  [23:0] partner_abil_in;
    wire  [31:0] partner_seed_in;
    wire  [43:0] partner_np_in, np_tx_out, np_rx_out;
    wire  [63:0] mac_word_out;
    cpmc_port_mode_control i_cpmc_port_mode_control (.*);
    cpmc_link_partner i_cpmc_link_partner (
        .clk_in(core_clk_in), .reset_in(reset_in), .plug_in(plug),
        .aneg_in(p_aneg), .wait_in(wt), .rate_in(rate), .abil_in(pabil),
        .seed_in(pseed), .np_send_in(psend), .np_word_in(npw),
        .pol_in(pol), .swap_in(swap), .energy_out(line_energy_in),
        .rate_out(line_rate_in), .page_out(partner_page_valid_in),
        .abil_out(partner_abil_in), .seed_out(partner_seed_in),
        .np_valid_out(partner_np_valid_in), .np_out(partner_np_in),
        .swap_out(cd_swap_in), .pol_out(pair_pol_err_in));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk_in);
    endtask
    task automatic neg(input logic [7:0] ps, input logic [2:0] exp);
        tick(1);
        plug[0] <= 1'h0;
        pseed <= ps;
        tick(3);
        plug[0] <= 1'h1;
        tick(60);
        #1;
        chk({link_up_out[0], master_out[0], ms_fault_out[0]}, exp);
    endtask
    initial begin
        core_clk_in = 1'h0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    // About 2.4 times the expected run
    initial begin
        tick(25000);
        n_errors++;
        conclude();
    end
    initial begin
        reset_in = 1'h1;
        {address_strap_pins_in, addr_reverse_in} = 4'hA;
        {aneg_en_in, speed_msb_in, forced_gig_test_in} = 12'h000;
        {speed_lsb_in, duplex_in} = 8'hEF;
        {auto_xover_dis_in, polarity_fix_dis_in, forced_xover_dis_in} = 12'h0;
        {manual_xover_in, mac_aneg_en_in, mac_sgmii_sel_in} = 16'h0011;
        {local_abil_in, local_seed_in} = 56'h00000F00000080;
        {mac_np_valid_in, psend, plug, pol} = 16'h00FA;
        {mac_np_in, npw} = 55'h00000005A52B7;
        {p_aneg, swap, rate, pabil} = 10'h34F;
        {wt, pseed} = 16'h0210;
        tick(8);
        chk(port_addr_out, 20'h00000);
        tick(8);
        reset_in <= 1'h0;
        for (int r = 0; r < 2; r++) begin
            tick(1);
            addr_reverse_in <= r[0];
            tick(3);
            #1;
            for (int i = 0; i < 4; i++)
                chk(port_addr_out[i*5 +: 5],
                    {3'h5, i[1:0] ^ {2{r[0]}}});
        end
        aneg_en_in[0] <= 1'h1;
        neg(8'h80, 3'h1);
        tick(1);
        {mac_np_valid_in[0], psend[0]} <= 2'h3;
        tick(1);
        {mac_np_valid_in[0], psend[0]} <= 2'h0;
        #1;
        chk({np_tx_valid_out[0], np_tx_out[10:0]}, 12'hB4A);
        tick(1);
        #1;
        chk({np_tx_valid_out[0], np_rx_valid_out[0], np_rx_out[10:0]},
            13'h0AB7);
        wt <= 8'h28;
        neg(8'hF0, 3'h4);
        neg(8'h10, 3'h6);
        chk({speed_out[1:0], duplex_out[0], aneg_done_out[0]}, 4'h7);
        tick(1);
        aneg_en_in[0] <= 1'h0;
        tick(4);
        #1;
        chk(aneg_done_out[0], 1'h0);
        foreach (rows[i]) begin
            tick(1);
            {speed_msb_in[0], speed_lsb_in[0], duplex_in[0]} <= rows[i][6:4];
            forced_gig_test_in[0] <= rows[i].t;
            tick(6);
            #1;
            chk({link_up_out[0], speed_out[1:0], duplex_out[0],
                gig_test_out[0]},
                {1'h1, rows[i].es, rows[i].d, rows[i].eg});
            chk(speed_out[7:2], 6'h15);
        end
        tick(1);
        {speed_msb_in[0], speed_lsb_in[0], duplex_in[0]} <= 3'h3;
        tick(6);
        #1;
        chk(mac_word_out[31:0], 32'h00009401);
        tick(1);
        mac_sgmii_sel_in[0] <= 1'h0;
        tick(2);
        #1;
        chk(mac_word_out[6:5], 2'h1);
        tick(1);
        mac_aneg_en_in[0] <= 1'h0;
        tick(2);
        #1;
        chk({mac_aneg_run_out, mac_word_out[15:0]}, 20'h00000);
        for (int m = 2; m < 4; m++) begin
            tick(1);
            manual_xover_in[1:0] <= m[1:0];
            tick(2);
            #1;
            chk({xover_auto_out[0], crossed_wiring_mode_out[0]},
                m[0]);
        end
        tick(1);
        {manual_xover_in[1:0], plug[0], aneg_en_in[0]} <= 4'h1;
        tick(3);
        #1;
        chk({xover_auto_out[0], cd_swap_out[0], polarity_inv_out[3:0]},
            6'h3A);
        last = crossed_wiring_mode_out[0];
        n = 0;
        repeat (2000) begin
            tick(1);
            #1;
            n += int'(crossed_wiring_mode_out[0] !== last);
            last = crossed_wiring_mode_out[0];
        end
        chk(n, 2);
        tick(1);
        {auto_xover_dis_in[0], polarity_fix_dis_in[0]} <= 2'h3;
        tick(2);
        #1;
        chk({xover_auto_out[0], crossed_wiring_mode_out[0],
            polarity_inv_out[3:0]}, 6'h00);
        for (int f = 0; f < 2; f++) begin
            tick(1);
            {auto_xover_dis_in[0], aneg_en_in[0]} <= 2'h0;
            forced_xover_dis_in[0] <= f[0];
            tick(2);
            #1;
            chk(xover_auto_out[0], !f[0]);
        end
        for (int r = 1; r < 3; r++) begin
            tick(1);
            {aneg_en_in[0], p_aneg, plug[0]} <= 3'h4;
            rate <= r[1:0];
            tick(3);
            plug[0] <= 1'h1;
            tick(4100);
            #1;
            chk({link_up_out[0], par_det_out[0]}, {2{r == 1}});
            if (r == 1)
                chk({speed_out[1:0], duplex_out[0]}, 3'h2);
        end
        conclude();
    end
endmodule
`default_nettype wire

/* verilog/cpmc_port_mode_control.v */
// Per-port copper mode, negotiation and crossover control, four ports
`include "cpmc_regs.vh"
`default_nettype none

module cpmc_port_mode_control (
    input  wire        core_clk_in,
    input  wire        reset_in,
    input  wire [2:0]  address_strap_pins_in,
    input  wire        addr_reverse_in,
    input  wire [3:0]  aneg_en_in,
    input  wire [3:0]  speed_lsb_in,
    input  wire [3:0]  speed_msb_in,
    input  wire [3:0]  duplex_in,
    input  wire [3:0]  forced_gig_test_in,
    input  wire [3:0]  auto_xover_dis_in,
    input  wire [3:0]  polarity_fix_dis_in,
    input  wire [3:0]  forced_xover_dis_in,
    input  wire [7:0]  manual_xover_in,
    input  wire [3:0]  mac_aneg_en_in,
    input  wire [3:0]  mac_sgmii_sel_in,
    input  wire [23:0] local_abil_in,
    input  wire [31:0] local_seed_in,
    input  wire [3:0]  line_energy_in,
    input  wire [7:0]  line_rate_in,
    input  wire [3:0]  partner_page_valid_in,
    input  wire [23:0] partner_abil_in,
    input  wire [31:0] partner_seed_in,
    input  wire [3:0]  mac_np_valid_in,
    input  wire [43:0] mac_np_in,
    input  wire [3:0]  partner_np_valid_in,
    input  wire [43:0] partner_np_in,
    input  wire [3:0]  cd_swap_in,
    input  wire [15:0] pair_pol_err_in,
    output wire [19:0] port_addr_out,
    output wire [3:0]  link_up_out,
    output wire [7:0]  speed_out,
    output wire [3:0]  duplex_out,
    output wire [3:0]  master_out,
    output wire [3:0]  aneg_done_out,
    output wire [3:0]  par_det_out,
    output wire [3:0]  gig_test_out,
    output wire [3:0]  ms_fault_out,
    output wire [3:0]  crossed_wiring_mode_out,
    output wire [3:0]  cd_swap_out,
    output wire [3:0]  xover_auto_out,
    output wire [15:0] polarity_inv_out,
    output wire [3:0]  np_tx_valid_out,
    output wire [43:0] np_tx_out,
    output wire [3:0]  np_rx_valid_out,
    output wire [43:0] np_rx_out,
    output wire [3:0]  mac_aneg_run_out,
    output wire [63:0] mac_word_out
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_ANEG   = 2'h1;
    localparam [1:0] ST_FORCED = 2'h2;
    localparam [1:0] ST_LINK   = 2'h3;

    localparam [11:0] XOVER_CYC = `CPMC_XOVER_CYC;
    localparam [11:0] ANEG_CYC  = `CPMC_ANEG_CYC;

    // Low address bits of a port, straight or reversed
    function [1:0] addr_low;
        input       rev;
        input [1:0] idx;
        begin
            addr_low = rev ? ~idx : idx;
        end
    endfunction

    // Best common mode: {found, speed, duplex}
    function [3:0] resolve;
        input [5:0] common;
        begin
            if (common[`CPMC_AB_1000F])
                resolve = {1'b1, `CPMC_SPD_1000, 1'b1};
            else if (common[`CPMC_AB_1000H])
                resolve = {1'b1, `CPMC_SPD_1000, 1'b0};
            else if (common[`CPMC_AB_100F])
                resolve = {1'b1, `CPMC_SPD_100, 1'b1};
            else if (common[`CPMC_AB_100H])
                resolve = {1'b1, `CPMC_SPD_100, 1'b0};
            else if (common[`CPMC_AB_10F])
                resolve = {1'b1, `CPMC_SPD_10, 1'b1};
            else if (common[`CPMC_AB_10H])
                resolve = {1'b1, `CPMC_SPD_10, 1'b0};
            else
                resolve = 4'h0;
        end
    endfunction

    // Word toward the MAC in SGMII or 1000BASE-X form
    function [15:0] mac_word;
        input       sgmii;
        input       link;
        input [1:0] spd;
        input       dpx;
        begin
            mac_word = `CPMC_RST_WORD;
            if (sgmii) begin
                mac_word[`CPMC_SG_FIXED]  = 1'b1;
                mac_word[`CPMC_SG_LINK]   = link;
                mac_word[`CPMC_SG_DPX]    = dpx;
                mac_word[`CPMC_SG_SPD_LO +: 2] = spd;
            end else begin
                mac_word[`CPMC_BX_FD] = dpx;
                mac_word[`CPMC_BX_HD] = ~dpx;
            end
        end
    endfunction

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_port
            localparam integer PNUM = i;

            reg  [4:0]  addr_reg;
            reg  [1:0]  st_reg;
            reg  [11:0] tmr_reg;
            reg  [11:0] xtmr_reg;
            reg  [4:0]  cfg_reg;
            reg  [1:0]  spd_reg;
            reg         dpx_reg;
            reg         ms_reg;
            reg         done_reg;
            reg         pd_reg;
            reg         gig_reg;
            reg         fault_reg;
            reg         crossed_reg;
            reg         cdsw_reg;
            reg  [3:0]  pol_reg;
            reg         np_tx_v_reg;
            reg  [10:0] np_tx_reg;
            reg         np_rx_v_reg;
            reg  [10:0] np_rx_reg;
            reg  [15:0] word_reg;

            wire [4:0] cfg_now = {aneg_en_in[i], speed_msb_in[i],
                                  speed_lsb_in[i], duplex_in[i],
                                  forced_gig_test_in[i]};
            wire [1:0] fspd    = {speed_msb_in[i], speed_lsb_in[i]};
            wire [3:0] res     = resolve(local_abil_in[6*i +: 6] &
                                         partner_abil_in[6*i +: 6]);
            wire [7:0] lseed   = local_seed_in[8*i +: 8];
            wire [7:0] pseed   = partner_seed_in[8*i +: 8];
            wire [1:0] prate   = line_rate_in[2*i +: 2];
            wire [1:0] man     = manual_xover_in[2*i +: 2];
            wire       link    = (st_reg == ST_LINK);
            wire       gig_now = ~aneg_en_in[i] & forced_gig_test_in[i] &
                                 (fspd == `CPMC_SPD_1000);
            // Forced gigabit keeps automatic crossover
            wire       auto_on = (man[1] == 1'b0) & ~auto_xover_dis_in[i] &
                                 (aneg_en_in[i] | ~forced_xover_dis_in[i] |
                                  gig_now);

            always @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    addr_reg <= 5'h00;
                end else begin
                    addr_reg <= {address_strap_pins_in,
                                 addr_low(addr_reverse_in, PNUM[1:0])};
                end
            end

            always @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    st_reg    <= ST_IDLE;
                    tmr_reg   <= 12'h000;
                    cfg_reg   <= `CPMC_RST_CFG;
                    spd_reg   <= `CPMC_SPD_10;
                    dpx_reg   <= 1'b0;
                    ms_reg    <= 1'b0;
                    done_reg  <= 1'b0;
                    pd_reg    <= 1'b0;
                    gig_reg   <= 1'b0;
                    fault_reg <= 1'b0;
                end else if (cfg_now != cfg_reg) begin
                    // Any mode change drops the link and starts over
                    cfg_reg  <= cfg_now;
                    st_reg   <= ST_IDLE;
                    done_reg <= 1'b0;
                    pd_reg   <= 1'b0;
                    gig_reg  <= 1'b0;
                end else begin
                    case (st_reg)
                    ST_IDLE: begin
                        tmr_reg   <= 12'h000;
                        done_reg  <= 1'b0;
                        pd_reg    <= 1'b0;
                        gig_reg   <= 1'b0;
                        fault_reg <= 1'b0;
                        st_reg    <= aneg_en_in[i] ? ST_ANEG
                                                   : ST_FORCED;
                    end
                    ST_ANEG: begin
                        if (partner_page_valid_in[i] && res[3]) begin
                            tmr_reg <= 12'h000;
                            if (lseed == pseed) begin
                                // Equal seeds: retry on the next page
                                fault_reg <= 1'b1;
                            end else begin
                                fault_reg <= 1'b0;
                                spd_reg   <= res[2:1];
                                dpx_reg   <= res[0];
                                ms_reg    <= (lseed > pseed);
                                done_reg  <= 1'b1;
                                st_reg    <= ST_LINK;
                            end
                        end else if (partner_page_valid_in[i]) begin
                            tmr_reg <= 12'h000;
                        end else if (tmr_reg == ANEG_CYC - 12'h001) begin
                            tmr_reg <= 12'h000;
                            // Gigabit cannot be found without pages
                            if (line_energy_in[i] &&
                                prate != `CPMC_SPD_1000) begin
                                spd_reg <= prate;
                                dpx_reg <= 1'b0;
                                ms_reg  <= 1'b0;
                                pd_reg  <= 1'b1;
                                st_reg  <= ST_LINK;
                            end
                        end else begin
                            tmr_reg <= tmr_reg + 12'h001;
                        end
                    end
                    ST_FORCED: begin
                        // Reserved speed code 11 falls back to 10 Mb/s
                        spd_reg <= (fspd == 2'h3) ? `CPMC_SPD_10
                                                  : fspd;
                        dpx_reg <= duplex_in[i];
                        ms_reg  <= 1'b0;
                        gig_reg <= gig_now;
                        if (line_energy_in[i])
                            st_reg <= ST_LINK;
                    end
                    ST_LINK: begin
                        if (!line_energy_in[i])
                            st_reg <= ST_IDLE;
                    end
                    default: st_reg <= ST_IDLE;
                    endcase
                end
            end

            // Crossover search and polarity capture
            always @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    xtmr_reg    <= 12'h000;
                    crossed_reg <= 1'b0;
                    cdsw_reg    <= 1'b0;
                    pol_reg     <= 4'h0;
                end else begin
                    if (man == `CPMC_MDX_STRAIGHT) begin
                        crossed_reg <= 1'b0;
                        xtmr_reg    <= 12'h000;
                    end else if (man == `CPMC_MDX_CROSSED) begin
                        crossed_reg <= 1'b1;
                        xtmr_reg    <= 12'h000;
                    end else if (!auto_on) begin
                        crossed_reg <= 1'b0;
                        xtmr_reg    <= 12'h000;
                    end else if (link || line_energy_in[i]) begin
                        xtmr_reg <= 12'h000;
                    end else if (xtmr_reg == XOVER_CYC - 12'h001) begin
                        xtmr_reg    <= 12'h000;
                        crossed_reg <= ~crossed_reg;
                    end else begin
                        xtmr_reg <= xtmr_reg + 12'h001;
                    end
                    // C/D swap is learned before link, then held
                    if (!link)
                        cdsw_reg <= cd_swap_in[i];
                    if (polarity_fix_dis_in[i])
                        pol_reg <= 4'h0;
                    else if (!link)
                        pol_reg <= pair_pol_err_in[4*i +: 4];
                end
            end

            // Next pages pass only while negotiation is in progress
            always @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    np_tx_v_reg <= 1'b0;
                    np_tx_reg   <= `CPMC_RST_NP;
                    np_rx_v_reg <= 1'b0;
                    np_rx_reg   <= `CPMC_RST_NP;
                    word_reg    <= `CPMC_RST_WORD;
                end else begin
                    np_tx_v_reg <= mac_np_valid_in[i] &
                                   (st_reg == ST_ANEG);
                    np_rx_v_reg <= partner_np_valid_in[i] &
                                   (st_reg == ST_ANEG);
                    if (mac_np_valid_in[i] && st_reg == ST_ANEG)
                        np_tx_reg <= mac_np_in[11*i +: 11];
                    if (partner_np_valid_in[i] && st_reg == ST_ANEG)
                        np_rx_reg <= partner_np_in[11*i +: 11];
                    word_reg <= mac_aneg_en_in[i] ?
                        mac_word(mac_sgmii_sel_in[i], link, spd_reg,
                                 dpx_reg) : `CPMC_RST_WORD;
                end
            end

            assign port_addr_out[5*i +: 5]     = addr_reg;
            assign link_up_out[i]              = link;
            assign speed_out[2*i +: 2]         = spd_reg;
            assign duplex_out[i]               = dpx_reg;
            assign master_out[i]               = ms_reg;
            assign aneg_done_out[i]            = done_reg;
            assign par_det_out[i]              = pd_reg;
            assign gig_test_out[i]             = gig_reg;
            assign ms_fault_out[i]             = fault_reg;
            assign crossed_wiring_mode_out[i]  = crossed_reg;
            assign cd_swap_out[i]              = cdsw_reg;
            assign xover_auto_out[i]           = auto_on;
            assign polarity_inv_out[4*i +: 4]  = pol_reg;
            assign np_tx_valid_out[i]          = np_tx_v_reg;
            assign np_tx_out[11*i +: 11]       = np_tx_reg;
            assign np_rx_valid_out[i]          = np_rx_v_reg;
            assign np_rx_out[11*i +: 11]       = np_rx_reg;
            assign mac_aneg_run_out[i]         = mac_aneg_en_in[i];
            assign mac_word_out[16*i +: 16]    = word_reg;
        end
    endgenerate

endmodule

`default_nettype wire

/* verilog/cpmc_regs.vh */
// Constants and timing for the per-port copper mode control block
// Function
// - Top three address bits of every port come from the shared strap pins
// - Low two address bits are the port index, optionally reversed
// - MAC-side SGMII negotiation runs only where that port enables it
// - Four ports share one QSGMII link; each picks SGMII or 1000BASE-X
// - Copper negotiation runs while enabled; clearing the enable stops it
// - Without negotiation, speed bits and duplex bit set the mode
// - A 10 or 100 Mb/s partner that never negotiates is found by parallel detection
// - Negotiation resolves speed, duplex, master role and relays next pages
// - Test bit plus speed bits 10 forces gigabit with no role setting
// - Crossover detected automatically; pair polarity detected and fixed
// - Crossover and polarity fixing on after reset; disables; status out
// - Forced 10/100 still crosses over when the forced-mode disable is 0
// - Straight, crossed and both with C/D pairs swapped all work
// - Manual field 10 forces straight, 11 crossed, 00 uses automatic
`ifndef CPMC_REGS_VH
`define CPMC_REGS_VH

`define CPMC_CLK_MHZ     12'hA
`define CPMC_XOVER_US    12'h64
`define CPMC_XOVER_CYC   (`CPMC_XOVER_US * `CPMC_CLK_MHZ)
`define CPMC_ANEG_US     12'h190
`define CPMC_ANEG_CYC    (`CPMC_ANEG_US * `CPMC_CLK_MHZ)

`define CPMC_SPD_10      2'h0
`define CPMC_SPD_100     2'h1
`define CPMC_SPD_1000    2'h2

`define CPMC_MDX_STRAIGHT 2'h2
`define CPMC_MDX_CROSSED  2'h3

`define CPMC_AB_10H      0
`define CPMC_AB_10F      1
`define CPMC_AB_100H     2
`define CPMC_AB_100F     3
`define CPMC_AB_1000H    4
`define CPMC_AB_1000F    5

`define CPMC_SG_FIXED    0
`define CPMC_SG_SPD_LO   10
`define CPMC_SG_DPX      12
`define CPMC_SG_LINK     15
`define CPMC_BX_FD       5
`define CPMC_BX_HD       6

`define CPMC_RST_CFG     5'h00
`define CPMC_RST_WORD    16'h0000
`define CPMC_RST_NP      11'h000

`endif
